// ### shared/portc_pad_pkg.sv
package portc_pad_pkg;
  localparam int          PIN_COUNT      = 3;
  localparam int          PIN_RX         = 0;
  localparam int          PIN_TX         = 1;
  localparam int          PIN_TIMER      = 2;
  localparam logic [7:0]  ADDR_FUNC_SEL  = 8'h00;
  localparam logic [7:0]  ADDR_PIN6_SERIAL = 8'h04;
  localparam logic [7:0]  ADDR_DIRECTION = 8'h08;
  localparam logic [7:0]  ADDR_DATA_OUT  = 8'h0C;
  localparam logic [7:0]  ADDR_PULLUP    = 8'h10;
  localparam logic [7:0]  ADDR_OPEN_DRAIN = 8'h14;
  localparam logic [7:0]  ADDR_PAD_IN    = 8'h18;
  localparam logic [7:0]  ADDR_PAD_STATE = 8'h1C;
  localparam logic [2:0]  RST_FUNC_SEL   = 3'h7;
  localparam logic        RST_PIN6_SERIAL = 1'h0;
  localparam logic [2:0]  RST_DIRECTION  = 3'h0;
  localparam logic [2:0]  RST_DATA_OUT   = 3'h0;
  localparam logic [2:0]  RST_PULLUP     = 3'h7;
  localparam logic [2:0]  RST_OPEN_DRAIN = 3'h0;
  localparam logic [2:0]  RST_PAD_IN     = 3'h7;
endpackage

// ### design/pad_drive_cell.sv
`timescale 1ns/1ps
module pad_drive_cell
(
  input  wire logic drive_en,
  input  wire logic drive_val,
  input  wire logic open_drain,
  input  wire logic pullup_en,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pullup
);
  always_comb
  begin
    pad_out    = drive_val;
    pad_oe     = drive_en;
    pad_pullup = pullup_en;
    if (drive_en && open_drain)
    begin
      // Open drain only ever pulls low; high is left to the pull-up
      pad_out    = 1'b0;
      pad_oe     = ~drive_val;
      pad_pullup = drive_val & pullup_en;
    end
    else if (drive_en)
    begin
      // Pull-up against a push-pull driver only wastes current
      pad_pullup = 1'b0;
    end
  end
endmodule

// ### design/portc_pad_mux_pullup.sv
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Function
// - Full variant: receive pad leaves reset selected to network-bus receive.
// - Full variant: transmit pad leaves reset selected to network-bus transmit.
// - Both variants: bit 6 pad leaves reset selected to timer C channel 0.
// - Each GPIO pin direction is set independently of the others.
// - Receive pad has a pull-up, kept on during reset.
// - Transmit pad is open drain with pull-up on at reset.
// - Open drain driving low turns its pull-up off.
// - Open drain outputting high turns pull-up on unless its enable bit is clear.
// - Push-pull output keeps the pull-up off at both levels.
module portc_pad_mux_pullup
#(
  parameter bit FULL_VARIANT = 1'b1
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        network_tx_data,
  output logic             network_rx_data,
  input  wire logic        timer_c_channel_zero_out,
  input  wire logic        timer_c_channel_zero_oe,
  output logic             timer_c_channel_zero_in,
  input  wire logic        serial0_transmit_out,
  input  wire logic [2:0]  pad_in,
  output logic [2:0]       pad_out,
  output logic [2:0]       pad_oe,
  output logic [2:0]       pad_pullup
);
  typedef struct packed {
    logic [2:0]  func_sel;
    logic        pin6_serial;
    logic [2:0]  direction;
    logic [2:0]  data_out;
    logic [2:0]  pullup_enable_register;
    logic [2:0]  open_drain;
    logic [2:0]  sync_first;
    logic [2:0]  sync_second;
    logic [2:0]  drive_q;
    logic [2:0]  od_q;
    logic [2:0]  pad_out;
    logic [2:0]  pad_oe;
    logic [2:0]  pad_pullup;
    logic        rx_data;
    logic        timer_in;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } state_type;

  state_type  st;
  state_type  next_st;
  logic [2:0] drive_en;
  logic [2:0] drive_val;
  logic [2:0] drive_od;
  logic [2:0] cell_out;
  logic [2:0] cell_oe;
  logic [2:0] cell_pullup;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == portc_pad_pkg::ADDR_FUNC_SEL) || (a == portc_pad_pkg::ADDR_PIN6_SERIAL)
      || (a == portc_pad_pkg::ADDR_DIRECTION) || (a == portc_pad_pkg::ADDR_DATA_OUT)
      || (a == portc_pad_pkg::ADDR_PULLUP) || (a == portc_pad_pkg::ADDR_OPEN_DRAIN)
      || (a == portc_pad_pkg::ADDR_PAD_IN) || (a == portc_pad_pkg::ADDR_PAD_STATE);
  endfunction

  // Pad ownership: peripheral when selected, GPIO registers otherwise
  always_comb
  begin
    drive_en  = st.direction;
    drive_val = st.data_out;
    drive_od  = st.open_drain;
    if (st.func_sel[portc_pad_pkg::PIN_RX])
    begin
      drive_en[portc_pad_pkg::PIN_RX]  = 1'b0;
      drive_val[portc_pad_pkg::PIN_RX] = 1'b0;
      drive_od[portc_pad_pkg::PIN_RX]  = 1'b0;
    end
    if (st.func_sel[portc_pad_pkg::PIN_TX])
    begin
      // Reduced variant has no network-bus unit: pad floats until reprogrammed
      drive_en[portc_pad_pkg::PIN_TX]  = FULL_VARIANT;
      drive_val[portc_pad_pkg::PIN_TX] = network_tx_data;
      drive_od[portc_pad_pkg::PIN_TX]  = 1'b1;
    end
    if (st.func_sel[portc_pad_pkg::PIN_TIMER])
    begin
      drive_od[portc_pad_pkg::PIN_TIMER] = 1'b0;
      if (st.pin6_serial)
      begin
        drive_en[portc_pad_pkg::PIN_TIMER]  = 1'b1;
        drive_val[portc_pad_pkg::PIN_TIMER] = serial0_transmit_out;
      end
      else
      begin
        drive_en[portc_pad_pkg::PIN_TIMER]  = timer_c_channel_zero_oe;
        drive_val[portc_pad_pkg::PIN_TIMER] = timer_c_channel_zero_out;
      end
    end
  end

  for (genvar k = 0; k < portc_pad_pkg::PIN_COUNT; k++)
  begin : g_cell
    pad_drive_cell u_cell
    (
      .drive_en   (drive_en[k]),
      .drive_val  (drive_val[k]),
      .open_drain (drive_od[k]),
      .pullup_en  (st.pullup_enable_register[k]),
      .pad_out    (cell_out[k]),
      .pad_oe     (cell_oe[k]),
      .pad_pullup (cell_pullup[k])
    );
  end

  always_comb
  begin
    next_st             = st;
    next_st.sync_first  = pad_in;
    next_st.sync_second = st.sync_first;
    next_st.drive_q     = drive_en;
    next_st.od_q        = drive_od;
    next_st.pad_out     = cell_out;
    next_st.pad_oe      = cell_oe;
    next_st.pad_pullup  = cell_pullup;
    next_st.rx_data     = FULL_VARIANT ? st.sync_second[portc_pad_pkg::PIN_RX] : 1'b1;
    next_st.timer_in    = st.sync_second[portc_pad_pkg::PIN_TIMER];
    // One wait state: data and pready come together on the second access cycle
    next_st.pready      = psel && penable && !st.pready;
    next_st.pslverr     = 1'b0;
    if (psel && penable && !st.pready)
    begin
      next_st.pslverr = !addr_known(paddr);
      next_st.prdata  = 32'h0000_0000;
      if (!pwrite)
      begin
        case (paddr)
          portc_pad_pkg::ADDR_FUNC_SEL:    next_st.prdata[2:0] = st.func_sel;
          portc_pad_pkg::ADDR_PIN6_SERIAL: next_st.prdata[0]   = st.pin6_serial;
          portc_pad_pkg::ADDR_DIRECTION:   next_st.prdata[2:0] = st.direction;
          portc_pad_pkg::ADDR_DATA_OUT:    next_st.prdata[2:0] = st.data_out;
          portc_pad_pkg::ADDR_PULLUP:      next_st.prdata[2:0] = st.pullup_enable_register;
          portc_pad_pkg::ADDR_OPEN_DRAIN:  next_st.prdata[2:0] = st.open_drain;
          portc_pad_pkg::ADDR_PAD_IN:      next_st.prdata[2:0] = st.sync_second;
          portc_pad_pkg::ADDR_PAD_STATE:   next_st.prdata[2:0] = st.pad_oe;
          default:                         next_st.prdata      = 32'h0000_0000;
        endcase
      end
    end
    if (psel && penable && st.pready && pwrite)
    begin
      case (paddr)
        portc_pad_pkg::ADDR_FUNC_SEL:    next_st.func_sel = pwdata[2:0];
        portc_pad_pkg::ADDR_PIN6_SERIAL: next_st.pin6_serial = pwdata[0];
        portc_pad_pkg::ADDR_DIRECTION:   next_st.direction = pwdata[2:0];
        portc_pad_pkg::ADDR_DATA_OUT:    next_st.data_out = pwdata[2:0];
        portc_pad_pkg::ADDR_PULLUP:      next_st.pullup_enable_register = pwdata[2:0];
        portc_pad_pkg::ADDR_OPEN_DRAIN:  next_st.open_drain = pwdata[2:0];
        default:                         next_st.open_drain = st.open_drain;
      endcase
    end
    if (!rstn)
    begin
      next_st = '0;
      next_st.func_sel    = portc_pad_pkg::RST_FUNC_SEL;
      next_st.pin6_serial = portc_pad_pkg::RST_PIN6_SERIAL;
      next_st.direction   = portc_pad_pkg::RST_DIRECTION;
      next_st.data_out    = portc_pad_pkg::RST_DATA_OUT;
      next_st.open_drain  = portc_pad_pkg::RST_OPEN_DRAIN;
      next_st.pullup_enable_register = portc_pad_pkg::RST_PULLUP;
      // Pads float with pull-ups on while reset is held
      next_st.pad_pullup  = portc_pad_pkg::RST_PULLUP;
      next_st.sync_first  = portc_pad_pkg::RST_PAD_IN;
      next_st.sync_second = portc_pad_pkg::RST_PAD_IN;
      next_st.rx_data     = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    st <= next_st;
  end

  assign prdata                  = st.prdata;
  assign pready                  = st.pready;
  assign pslverr                 = st.pslverr;
  assign network_rx_data         = st.rx_data;
  assign timer_c_channel_zero_in = st.timer_in;
  assign pad_out                 = st.pad_out;
  assign pad_oe                  = st.pad_oe;
  assign pad_pullup              = st.pad_pullup;

  sequence s_reset_held;
    !rstn;
  endsequence

  property p_rx_default;
    @(posedge clk) s_reset_held ##1 rstn |-> (st.func_sel[0] || !FULL_VARIANT);
  endproperty
  a_rx_default: assert property (p_rx_default) else $error("rx pad not selected");

  property p_tx_default;
    @(posedge clk) (s_reset_held and FULL_VARIANT) |=> st.func_sel[1] && st.od_q[1] == 1'b0;
  endproperty
  a_tx_default: assert property (p_tx_default) else $error("tx pad not selected");

  property p_timer_default;
    @(posedge clk) s_reset_held |=> st.func_sel[2] && !st.pin6_serial;
  endproperty
  a_timer_default: assert property (p_timer_default) else $error("timer not default");

  property p_direction_alone;
    @(posedge clk) disable iff (!rstn)
      ((~$past(st.func_sel) & $past(st.direction) & ~$past(st.open_drain)) & ~pad_oe) == 3'h0;
  endproperty
  a_direction_alone: assert property (p_direction_alone) else $error("gpio not driving");

  property p_reset_pullups;
    @(posedge clk) s_reset_held |=> pad_pullup[0] && pad_pullup[1] && pad_oe == 3'h0;
  endproperty
  a_reset_pullups: assert property (p_reset_pullups) else $error("reset pull-up off");

  property p_od_low;
    @(posedge clk) disable iff (!rstn) (pad_oe & st.od_q & pad_pullup) == 3'h0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("pull-up on while sinking");

  property p_od_high;
    @(posedge clk) disable iff (!rstn)
      (st.drive_q & st.od_q & ~pad_oe & (pad_pullup ^ $past(st.pullup_enable_register))) == 3'h0;
  endproperty
  a_od_high: assert property (p_od_high) else $error("open-drain high pull-up wrong");

  property p_push_pull;
    @(posedge clk) disable iff (!rstn) (st.drive_q & ~st.od_q & pad_pullup) == 3'h0;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("pull-up on push-pull");

  property p_periph_owns;
    @(posedge clk) disable iff (!rstn)
      $past(st.func_sel[2] && !st.pin6_serial) |-> pad_oe[2] == $past(timer_c_channel_zero_oe)
        && (!pad_oe[0] || !$past(st.func_sel[0]));
  endproperty
  a_periph_owns: assert property (p_periph_owns) else $error("gpio leaks to pad");
endmodule

// ### verif/pad_board_model.sv
`timescale 1ns/1ps
module pad_board_model
(
  input  wire logic       clk,
  input  wire logic [2:0] pad_out,
  input  wire logic [2:0] pad_oe,
  input  wire logic [2:0] pad_pullup,
  input  wire logic [2:0] ext_en,
  input  wire logic [2:0] ext_val,
  output logic      [2:0] pad_in
);
  // A pad nobody drives and nothing pulls toggles, so a stale level never reads as valid
  logic [2:0] float_val = 3'h5;
  always_ff @(posedge clk)
  begin
    float_val <= ~float_val;
  end
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_pullup[i])
        pad_in[i] = 1'h1;
      else
        pad_in[i] = float_val[i];
    end
  end
endmodule

// ### verif/port_c_pad_mux_pullup_tb.sv
`timescale 1ns/1ps
module port_c_pad_mux_pullup_tb;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_data = 1'h1;
  logic        rx_data;
  logic        tmr_out = 1'h0;
  logic        tmr_oe = 1'h0;
  logic        tmr_in;
  logic        ser_out = 1'h0;
  logic [2:0]  pad_in;
  logic [2:0]  pad_out;
  logic [2:0]  pad_oe;
  logic [2:0]  pad_pullup;
  logic [2:0]  ext_en = 3'h0;
  logic [2:0]  ext_val = 3'h0;
  logic [31:0] rd_data;
  logic        rd_err;
  int          miscompares = 0;
  int          num_checks = 0;
  always #25 clk = ~clk;
  portc_pad_mux_pullup u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .network_tx_data(tx_data), .network_rx_data(rx_data),
    .timer_c_channel_zero_out(tmr_out), .timer_c_channel_zero_oe(tmr_oe),
    .timer_c_channel_zero_in(tmr_in), .serial0_transmit_out(ser_out), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup));
  pad_board_model u_board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // Master holds the request until pready is sampled high or 20 cycles pass, no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'h1)
        break;
    end
    if (n == 20)
    begin
      miscompares++;
      end_of_test();
    end
    else
    begin
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(name, rd_data, exp);
  endtask
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask
  task automatic test_reset_defaults;
    rd_chk("func_sel", portc_pad_pkg::ADDR_FUNC_SEL, 32'h7);
    rd_chk("pin6_serial", portc_pad_pkg::ADDR_PIN6_SERIAL, 32'h0);
    rd_chk("pullup_reg", portc_pad_pkg::ADDR_PULLUP, 32'h7);
    chk("rx_idle", rx_data, 1'h1);
    ext_en <= 3'h1;
    tmr_oe <= 1'h1;
    tmr_out <= 1'h1;
    settle();
    chk("rx_low", rx_data, 1'h0);
    chk("timer_pad", {pad_oe[2], pad_out[2]}, 2'h3);
    chk("timer_in_high", tmr_in, 1'h1);
    ext_en <= 3'h0;
  endtask
  task automatic test_tx_open_drain;
    chk("tx_high", {pad_oe[1], pad_pullup[1]}, 2'h1);
    tx_data <= 1'h0;
    settle();
    chk("tx_low", {pad_oe[1], pad_out[1], pad_pullup[1]}, 3'h4);
    tx_data <= 1'h1;
    apb(1'h1, portc_pad_pkg::ADDR_PULLUP, 32'h5);
    settle();
    chk("tx_pu_off", pad_pullup[1], 1'h0);
    apb(1'h1, portc_pad_pkg::ADDR_PULLUP, 32'h7);
  endtask
  task automatic test_gpio;
    apb(1'h1, portc_pad_pkg::ADDR_FUNC_SEL, 32'h0);
    apb(1'h1, portc_pad_pkg::ADDR_DIRECTION, 32'h2);
    apb(1'h1, portc_pad_pkg::ADDR_DATA_OUT, 32'h7);
    settle();
    chk("dir_one", pad_oe, 3'h2);
    chk("pp_pullup", pad_pullup, 3'h5);
    apb(1'h1, portc_pad_pkg::ADDR_DIRECTION, 32'h5);
    settle();
    chk("dir_two", pad_oe, 3'h5);
    apb(1'h1, portc_pad_pkg::ADDR_OPEN_DRAIN, 32'h7);
    apb(1'h1, portc_pad_pkg::ADDR_DIRECTION, 32'h7);
    apb(1'h1, portc_pad_pkg::ADDR_DATA_OUT, 32'h2);
    settle();
    chk("od_pullup", pad_pullup, 3'h2);
    rd_chk("pad_state", portc_pad_pkg::ADDR_PAD_STATE, 32'h5);
    rd_chk("pad_levels", portc_pad_pkg::ADDR_PAD_IN, 32'h2);
  endtask
  task automatic test_periph_override;
    apb(1'h1, portc_pad_pkg::ADDR_OPEN_DRAIN, 32'h0);
    apb(1'h1, portc_pad_pkg::ADDR_DATA_OUT, 32'h0);
    apb(1'h1, portc_pad_pkg::ADDR_FUNC_SEL, 32'h7);
    apb(1'h1, portc_pad_pkg::ADDR_PIN6_SERIAL, 32'h1);
    tmr_oe <= 1'h0;
    ser_out <= 1'h1;
    settle();
    chk("tx_ignores_gpio", {pad_oe[1], pad_pullup[1]}, 2'h1);
    chk("rx_ignores_gpio", pad_oe[0], 1'h0);
    chk("serial_pad", {pad_oe[2], pad_out[2], pad_pullup[2]}, 3'h6);
    ser_out <= 1'h0;
    settle();
    chk("serial_low", {pad_oe[2], pad_out[2], pad_pullup[2]}, 3'h4);
    chk("timer_in_low", tmr_in, 1'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped_err", rd_err, 1'h1);
    chk("unmapped_data", rd_data, 32'h0);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    chk("reset_pullup", pad_pullup, 3'h7);
    chk("reset_oe", pad_oe, 3'h0);
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    settle();
    test_reset_defaults();
    test_tx_open_drain();
    test_gpio();
    test_periph_override();
    end_of_test();
  end
endmodule
